// ---- src/pesb_regs.sv ----
// Extended status and bypass control registers behind the serial management port
`include "pesb_params.svh"

module pesb_regs
  import pesb_pkg::*;
(
  // Clock and resets
  input wire logic clk,
  input wire logic rst,
  input wire logic soft_reset,
  // Serial management port pins
  input wire logic mdc,
  input wire logic mdio_rx,
  output logic mdio_drv,
  output logic mdio_oe,
  // Straps
  input wire logic [4:0] phy_addr,
  input wire logic config_strap_default,
  // Receive path status from the datapaths
  input wire pesb_fast_evt_t fast_evt,
  input wire pesb_live_t fast_live,
  input wire pesb_giga_evt_t giga_evt,
  input wire pesb_live_t giga_live,
  input wire logic legacy_partner_raw,
  input wire logic mdi_xover_err,
  // Controls to the datapaths
  output pesb_bypass_ctrl_t ctrl,
  output logic legacy_partner_flag
);

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  function automatic logic addr_hit(input logic [4:0] a);
    addr_hit = (a >= `PESB_ADDR_RSVD_LO) && (a <= `PESB_ADDR_BYP);
  endfunction : addr_hit

  // Pin synchronisation
  logic [7:0] pin_s;
  logic mdc_s, mdio_s, strap_s;
  logic [4:0] phy_s;
  logic mdc_d_r, mdc_rise;

  pesb_sync2 #(.W(8)) u_pin_sync (
    .clk(clk), .d({mdc, mdio_rx, config_strap_default, phy_addr}), .q(pin_s));

  assign mdc_s = pin_s[7];
  assign mdio_s = pin_s[6];
  assign strap_s = pin_s[5];
  assign phy_s = pin_s[4:0];
  // Idle mdc is low, so the delayed copy resets low and no false edge follows reset
  assign mdc_rise = mdc_s & ~mdc_d_r;

  // Frame engine state
  pesb_state_t state_r, state_nxt;
  logic [5:0] cnt_r, cnt_nxt;
  logic [11:0] hdr_r, hdr_nxt;
  logic [15:0] dat_r, dat_nxt;
  logic rd_r, rd_nxt, mine_r, mine_nxt;
  logic [4:0] addr_r, addr_nxt;
  logic mdio_drv_r, mdio_drv_nxt, mdio_oe_r, mdio_oe_nxt;
  logic rd_load, wr_commit;
  logic [12:0] hdr_full;
  logic [1:0] hdr_op;
  logic hdr_ok, hdr_mine;
  logic [15:0] wr_data, rd_word;

  // Status and control state
  logic [15:0] byp_r, byp_nxt, byp_sticky;
  logic leg_r, leg_nxt, fast_clr, giga_clr, latch_rst;
  logic [5:0] fast_q;
  logic [6:0] giga_q;

  assign hdr_full = {hdr_r, mdio_s};
  assign hdr_op = hdr_full[11:10];
  assign hdr_ok = hdr_full[12] && ((hdr_op == `PESB_OP_RD) || (hdr_op == `PESB_OP_WR));
  assign hdr_mine = hdr_ok && (hdr_full[9:5] == phy_s) && addr_hit(hdr_full[4:0]);
  assign wr_data = {dat_r[14:0], mdio_s};

  // Read snapshot; every address of the bank not listed below reads zero
  always_comb begin
    rd_word = 16'h0000;
    case (hdr_full[4:0])
      `PESB_ADDR_GCAP: rd_word = `PESB_GCAP_VAL;
      `PESB_ADDR_FAST: begin
        rd_word[`PESB_ST_LOCK] = fast_live.descrambler_lock;
        rd_word[`PESB_ST_LINK] = fast_live.link_up;
        rd_word[`PESB_ST_ERRA -: 2] = fast_q[5:4];
        rd_word[`PESB_ST_ERRB -: 4] = fast_q[3:0];
      end
      `PESB_ADDR_GIGA: begin
        rd_word[`PESB_ST_LOCK] = giga_live.descrambler_lock;
        rd_word[`PESB_ST_LINK] = giga_live.link_up;
        rd_word[`PESB_ST_ERRA -: 2] = giga_q[6:5];
        rd_word[`PESB_ST_ERRB -: 4] = giga_q[4:1];
        rd_word[`PESB_ST_CEXT] = giga_q[0];
        rd_word[`PESB_ST_LEGACY] = leg_r;
        rd_word[`PESB_ST_XOVER] = mdi_xover_err;
      end
      `PESB_ADDR_BYP: rd_word = byp_r;
      default: rd_word = 16'h0000;
    endcase
  end

  // Management frame: preamble, start, opcode, addresses, turnaround, data
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    hdr_nxt = hdr_r;
    dat_nxt = dat_r;
    rd_nxt = rd_r;
    mine_nxt = mine_r;
    addr_nxt = addr_r;
    mdio_drv_nxt = mdio_drv_r;
    mdio_oe_nxt = mdio_oe_r;
    rd_load = 1'b0;
    wr_commit = 1'b0;
    if (mdc_rise) begin
      case (state_r)
        PESB_PRE: begin
          if (mdio_s) begin
            if (cnt_r != `PESB_PREAMBLE_LEN) begin
              cnt_nxt = cnt_r + 6'd1;
            end
          end else if (cnt_r == `PESB_PREAMBLE_LEN) begin
            state_nxt = PESB_HDR;
            cnt_nxt = 6'd0;
          end else begin
            cnt_nxt = 6'd0;
          end
        end
        PESB_HDR: begin
          hdr_nxt = hdr_full[11:0];
          cnt_nxt = cnt_r + 6'd1;
          if (cnt_r == `PESB_HDR_LAST) begin
            cnt_nxt = 6'd0;
            rd_nxt = (hdr_op == `PESB_OP_RD);
            addr_nxt = hdr_full[4:0];
            mine_nxt = hdr_mine;
            state_nxt = hdr_ok ? PESB_TA : PESB_PRE;
            if (hdr_mine && (hdr_op == `PESB_OP_RD)) begin
              rd_load = 1'b1;
              dat_nxt = rd_word;
            end
          end
        end
        PESB_TA: begin
          cnt_nxt = cnt_r + 6'd1;
          if (rd_r) begin
            // Drive the second turnaround bit low when addressed
            mdio_oe_nxt = mine_r;
            mdio_drv_nxt = 1'b0;
            state_nxt = PESB_DAT;
            cnt_nxt = 6'd0;
          end else if (cnt_r == `PESB_TA_LAST) begin
            state_nxt = PESB_DAT;
            cnt_nxt = 6'd0;
          end
        end
        PESB_DAT: begin
          cnt_nxt = cnt_r + 6'd1;
          if (rd_r) begin
            if (cnt_r == `PESB_DAT_BITS) begin
              mdio_oe_nxt = 1'b0;
              mdio_drv_nxt = 1'b0;
              state_nxt = PESB_PRE;
              cnt_nxt = 6'd0;
            end else begin
              mdio_drv_nxt = dat_r[15];
              dat_nxt = {dat_r[14:0], 1'b0};
            end
          end else begin
            dat_nxt = wr_data;
            if (cnt_r == `PESB_DAT_LAST) begin
              wr_commit = mine_r;
              state_nxt = PESB_PRE;
              cnt_nxt = 6'd0;
            end
          end
        end
        default: begin
          state_nxt = PESB_PRE;
          cnt_nxt = 6'd0;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= PESB_PRE;
      cnt_r <= 6'd0;
      hdr_r <= 12'h000;
      dat_r <= 16'h0000;
      rd_r <= 1'b0;
      mine_r <= 1'b0;
      addr_r <= 5'h00;
      mdio_drv_r <= 1'b0;
      mdio_oe_r <= 1'b0;
      mdc_d_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      hdr_r <= hdr_nxt;
      dat_r <= dat_nxt;
      rd_r <= rd_nxt;
      mine_r <= mine_nxt;
      addr_r <= addr_nxt;
      mdio_drv_r <= mdio_drv_nxt;
      mdio_oe_r <= mdio_oe_nxt;
      mdc_d_r <= mdc_s;
    end
  end

  assign mdio_drv = mdio_drv_r;
  assign mdio_oe = mdio_oe_r;

  // Clear-on-read pulses land in the snapshot cycle, so the value read is the one cleared
  assign fast_clr = rd_load && (hdr_full[4:0] == `PESB_ADDR_FAST);
  assign giga_clr = rd_load && (hdr_full[4:0] == `PESB_ADDR_GIGA);
  assign latch_rst = rst | soft_reset;

  pesb_evt_latch #(.W(6)) u_fast_latch (
    .clk(clk), .rst(latch_rst), .set(fast_evt), .clr(fast_clr), .q(fast_q));

  pesb_evt_latch #(.W(7)) u_giga_latch (
    .clk(clk), .rst(latch_rst), .set(giga_evt), .clr(giga_clr), .q(giga_q));

  // Bypass control; soft reset outranks a write landing in the same cycle
  always_comb begin
    byp_nxt = byp_r;
    if (soft_reset) begin
      byp_nxt = (byp_r & `PESB_BYP_STICKY) | (`PESB_BYP_RST & ~`PESB_BYP_STICKY);
    end else if (wr_commit && (addr_r == `PESB_ADDR_BYP)) begin
      byp_nxt = wr_data & `PESB_BYP_WMASK;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      byp_r <= (`PESB_BYP_RST & ~`PESB_BYP_STRAP) | {15'h0000, strap_s};
    end else begin
      byp_r <= byp_nxt;
    end
  end

  assign byp_sticky = byp_r & `PESB_BYP_STICKY;

  // Legacy partner outcome: forcing wins over the disable
  always_comb begin
    leg_nxt = byp_r[`PESB_BYP_FORCE_LEG] |
              (legacy_partner_raw & ~byp_r[`PESB_BYP_LEG_DIS]);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      leg_r <= 1'b0;
    end else begin
      leg_r <= leg_nxt;
    end
  end

  assign legacy_partner_flag = leg_r;

  always_comb begin
    ctrl.tx_disable = byp_r[`PESB_BYP_TXDIS];
    ctrl.tx_test_clk_en = byp_r[`PESB_BYP_TCLK];
    ctrl.force_legacy_det = byp_r[`PESB_BYP_FORCE_LEG];
    ctrl.legacy_det_disable = byp_r[`PESB_BYP_LEG_DIS];
    ctrl.pair_swap_corr_dis = byp_r[`PESB_BYP_PSWAP_DIS];
    ctrl.polarity_corr_dis = byp_r[`PESB_BYP_POL_DIS];
    ctrl.pd_honour_adv = byp_r[`PESB_BYP_PD_ADV];
    // Negotiation stops after the base page and waits for management
    ctrl.auto_np_dis = byp_r[`PESB_BYP_NP_DIS];
    ctrl.clock_output_en = byp_r[`PESB_BYP_CLKO];
  end

  // Checks
  sequence s_rd_snap(logic [4:0] a);
    rd_load && (hdr_full[4:0] == a);
  endsequence

  sequence s_ta_rd;
    (state_r == PESB_TA) && rd_r && mine_r && mdc_rise;
  endsequence

  chk_rsvd_zero: assert property (
    rd_load && (hdr_full[4:0] <= `PESB_ADDR_RSVD_HI) |=> (dat_r == 16'h0000))
    else $error("reserved address read nonzero");
  chk_gcap_value: assert property (
    s_rd_snap(`PESB_ADDR_GCAP) |=> (dat_r == `PESB_GCAP_VAL))
    else $error("capability word wrong");
  chk_fast_live: assert property (
    s_rd_snap(`PESB_ADDR_FAST) |=> (dat_r[15] == $past(fast_live.descrambler_lock)) &&
      (dat_r[12] == $past(fast_live.link_up)))
    else $error("fast live bits wrong");
  chk_fast_rdclr: assert property (
    s_rd_snap(`PESB_ADDR_FAST) ##0 !soft_reset |=> (fast_q == $past(fast_evt)))
    else $error("fast flags not cleared by read");
  chk_giga_live: assert property (
    s_rd_snap(`PESB_ADDR_GIGA) |=> (dat_r[15] == $past(giga_live.descrambler_lock)) &&
      (dat_r[12] == $past(giga_live.link_up)))
    else $error("gigabit live bits wrong");
  chk_giga_latch: assert property (
    (|giga_evt) && !soft_reset |=> ((giga_q & $past(giga_evt)) == $past(giga_evt)))
    else $error("gigabit event lost");
  chk_giga_report: assert property (
    s_rd_snap(`PESB_ADDR_GIGA) |=> (dat_r[6] == $past(leg_r)) &&
      (dat_r[5] == $past(mdi_xover_err)))
    else $error("legacy or crossover bit wrong");
  chk_hw_defaults: assert property (
    $past(rst) |-> ((byp_r & ~`PESB_BYP_STRAP) == (`PESB_BYP_RST & ~`PESB_BYP_STRAP)))
    else $error("bypass reset value wrong");
  chk_strap_default: assert property (
    $past(rst) |-> (byp_r[0] == $past(strap_s)))
    else $error("clock output enable not taken from strap");
  chk_legacy_gate: assert property (
    byp_r[`PESB_BYP_LEG_DIS] && !byp_r[`PESB_BYP_FORCE_LEG] |=> !leg_r)
    else $error("legacy detection not disabled");
  chk_soft_sticky: assert property (
    soft_reset |=> (byp_sticky == $past(byp_sticky)) && ((byp_r & ~`PESB_BYP_STICKY) == 16'h0000))
    else $error("soft reset disturbed sticky bits");
  chk_write_mask: assert property (
    wr_commit && (addr_r == `PESB_ADDR_BYP) && !soft_reset |=>
      (byp_r == ($past(wr_data) & `PESB_BYP_WMASK)))
    else $error("bypass write wrong");
  chk_ta_drive: assert property (
    s_ta_rd |=> mdio_oe && !mdio_drv)
    else $error("turnaround not driven low");

endmodule : pesb_regs

// ---- inc/pesb_params.svh ----
// Register offsets, field positions, reset values and frame counts of the bank
// Function
// - Addresses 0x0B through 0x0E are reserved: they read as zero and ignore writes.
// - The gigabit capability register reads 0x3000: twisted-pair gigabit full and half only.
// - Fast status bits 15 and 12 show live descrambler lock and live link, never cleared by a read.
// - Fast status bits 14, 13 and 11 to 8 latch their error events and clear when read.
// - Gigabit status bits 15 and 12 show live descrambler lock and live link, never cleared by a read.
// - Gigabit status bits 14, 13 and 11 to 7 latch their error events and clear when read.
// - Gigabit status bit 6 shows a detected legacy partner and bit 5 an MDI crossover error.
// - Bypass bit 15, zero after reset, turns the line transmitter off when one.
// - Bypass bit 7 forces legacy partner detection and bit 6, one after reset, disables it.
// - Bypass bit 5, zero after reset, turns automatic pair swap correction off when one.
// - Bypass bit 4, zero after reset, turns automatic polarity correction off when one.
// - Bypass bit 3, one after reset, makes parallel detection honour advertised abilities.
// - Bypass bit 1 stops automatic gigabit next pages and hands control back after the base page.
// - Bypass bit 0 enables the clock output pin and takes its reset value from the strap.
`ifndef PESB_PARAMS_SVH
`define PESB_PARAMS_SVH

`define PESB_ADDR_RSVD_LO 5'h0b
`define PESB_ADDR_RSVD_HI 5'h0e
`define PESB_ADDR_GCAP 5'h0f
`define PESB_ADDR_FAST 5'h10
`define PESB_ADDR_GIGA 5'h11
`define PESB_ADDR_BYP 5'h12

`define PESB_GCAP_VAL 16'h3000
`define PESB_BYP_RST 16'h0048
`define PESB_BYP_WMASK 16'h81fb
`define PESB_BYP_STICKY 16'h00fb
`define PESB_BYP_STRAP 16'h0001

`define PESB_BYP_TXDIS 15
`define PESB_BYP_TCLK 8
`define PESB_BYP_FORCE_LEG 7
`define PESB_BYP_LEG_DIS 6
`define PESB_BYP_PSWAP_DIS 5
`define PESB_BYP_POL_DIS 4
`define PESB_BYP_PD_ADV 3
`define PESB_BYP_NP_DIS 1
`define PESB_BYP_CLKO 0

`define PESB_ST_LOCK 15
`define PESB_ST_ERRA 14
`define PESB_ST_LINK 12
`define PESB_ST_ERRB 11
`define PESB_ST_CEXT 7
`define PESB_ST_LEGACY 6
`define PESB_ST_XOVER 5

`define PESB_PREAMBLE_LEN 6'd32
`define PESB_HDR_LAST 6'd12
`define PESB_TA_LAST 6'd1
`define PESB_DAT_BITS 6'd16
`define PESB_DAT_LAST 6'd15
`define PESB_OP_RD 2'b10
`define PESB_OP_WR 2'b01

`endif

// ---- inc/pesb_pkg.sv ----
// Types shared by the extended status and bypass register bank
package pesb_pkg;

  typedef enum logic [1:0] {
    PESB_PRE = 2'b00,
    PESB_HDR = 2'b01,
    PESB_TA = 2'b11,
    PESB_DAT = 2'b10
  } pesb_state_t;

  typedef struct packed {
    logic lock_err;
    logic disconnect;
    logic rx_err;
    logic tx_err;
    logic start_stream_delimiter_err;
    logic end_stream_delimiter_err;
  } pesb_fast_evt_t;

  typedef struct packed {
    logic lock_err;
    logic disconnect;
    logic rx_err;
    logic tx_err;
    logic start_stream_delimiter_err;
    logic end_stream_delimiter_err;
    logic carrier_ext_err;
  } pesb_giga_evt_t;

  typedef struct packed {
    logic descrambler_lock;
    logic link_up;
  } pesb_live_t;

  typedef struct packed {
    logic tx_disable;
    logic tx_test_clk_en;
    logic force_legacy_det;
    logic legacy_det_disable;
    logic pair_swap_corr_dis;
    logic polarity_corr_dis;
    logic pd_honour_adv;
    logic auto_np_dis;
    logic clock_output_en;
  } pesb_bypass_ctrl_t;

endpackage : pesb_pkg

// ---- src/pesb_sync2.sv ----
// Two-stage synchroniser for pins from outside the clock domain
module pesb_sync2 #(
  parameter int W = 1
) (
  // Clock
  input wire logic clk,
  // Asynchronous levels and their synchronised copies
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;

  // No reset: the stages settle within two edges of any reset
  always_ff @(posedge clk) begin
    meta_r <= d;
    sync_r <= meta_r;
  end

  assign q = sync_r;

endmodule : pesb_sync2

// ---- src/pesb_evt_latch.sv ----
// Event flags that latch high and clear on read, a new event beating the clear
module pesb_evt_latch #(
  parameter int W = 6
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Events and read clear
  input wire logic [W-1:0] set,
  input wire logic clr,
  // Flags
  output logic [W-1:0] q
);
  logic [W-1:0] q_r;
  logic [W-1:0] q_nxt;

  always_comb begin
    q_nxt = (q_r & ~{W{clr}}) | set;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign q = q_r;

endmodule : pesb_evt_latch

// ---- testbench/pesb_smi_master.sv ----
// Station management controller model that runs whole serial frames
module pesb_smi_master (
  // Clock
  input wire logic clk,
  // Serial management port pins, controller side
  output logic mdc,
  output logic mdio_out,
  output logic mdio_oe,
  input wire logic mdio_in
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    mdc = 1'b0;
    mdio_out = 1'b1;
    mdio_oe = 1'b0;
  end

  // Five clk low and six clk high per mdc bit keeps the pin slow enough for the device's sampler
  task automatic slot(input logic drive, input logic bit_v, output logic smp);
    @(negedge clk);
    mdc = 1'b0;
    mdio_oe = drive;
    mdio_out = bit_v;
    repeat (5) @(negedge clk);
    smp = mdio_in;
    mdc = 1'b1;
    repeat (5) @(negedge clk);
  endtask : slot

  // The controller forces any configuration by hand through these frames
  task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] ra,
                       input logic [15:0] wd, output logic [15:0] rdat, output logic ta2);
    logic [63:0] bits;
    logic s;
    bits = {32'hffff_ffff, 2'b01, op, phy, ra, 2'b10, wd};
    for (int i = 63; i >= 0; i--) begin
      // Reads release the line from the first turnaround bit on
      slot(op == 2'b01 || i > 17, bits[i], s);
      if (i == 16) ta2 = s;
      if (i < 16) rdat[i] = s;
    end
    @(negedge clk);
    mdc = 1'b0;
    mdio_oe = 1'b0;
    repeat (10) @(negedge clk);
  endtask : frame
endmodule : pesb_smi_master

// ---- testbench/pesb_regs_tb_top.sv ----
// Self-checking bench for the extended status and bypass register bank
`include "pesb_params.svh"

module pesb_regs_tb_top import pesb_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;

  localparam logic [4:0] PHY = 5'h03;
  localparam logic [15:0] BYP_VALS [10] = '{16'hffff, 16'h8000, 16'h0100, 16'h0080,
    16'h0040, 16'h0020, 16'h0010, 16'h0008, 16'h0002, 16'h0001};
  localparam logic [15:0] FAST_BITS [6] = '{16'h4000, 16'h2000, 16'h0800, 16'h0400,
    16'h0200, 16'h0100};
  localparam logic [15:0] GIGA_BITS [7] = '{16'h4000, 16'h2000, 16'h0800, 16'h0400,
    16'h0200, 16'h0100, 16'h0080};

  logic clk = 1'b0;
  logic rst = 1'b1;
  logic soft_reset = 1'b0;
  logic strap = 1'b1;
  logic raw = 1'b0;
  logic xover = 1'b0;
  pesb_fast_evt_t fevt = '0;
  pesb_giga_evt_t gevt = '0;
  pesb_live_t flive = '0;
  pesb_live_t glive = '0;
  pesb_bypass_ctrl_t ctrl;
  logic leg_flag;
  logic mdc;
  logic mdio_drv;
  logic mdio_oe;
  logic m_out;
  logic m_oe;
  logic mdio_w;
  int n_fail = 0;
  int checks_done = 0;

  // Data line has a pull-up, so a released line reads one
  assign mdio_w = mdio_oe ? mdio_drv : (m_oe ? m_out : 1'b1);

  always #50 clk = ~clk;

  pesb_regs pesb_regs_inst (
    .clk(clk), .rst(rst), .soft_reset(soft_reset), .mdc(mdc), .mdio_rx(mdio_w),
    .mdio_drv(mdio_drv), .mdio_oe(mdio_oe), .phy_addr(PHY), .config_strap_default(strap),
    .fast_evt(fevt), .fast_live(flive), .giga_evt(gevt), .giga_live(glive),
    .legacy_partner_raw(raw), .mdi_xover_err(xover), .ctrl(ctrl),
    .legacy_partner_flag(leg_flag)
  );

  pesb_smi_master pesb_smi_master_inst (
    .clk(clk), .mdc(mdc), .mdio_out(m_out), .mdio_oe(m_oe), .mdio_in(mdio_w)
  );

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic rd(input logic [4:0] ra, input logic [15:0] exp, input string what);
    logic [15:0] d;
    logic t;
    pesb_smi_master_inst.frame(`PESB_OP_RD, PHY, ra, 16'h0000, d, t);
    chk(16'(t), 16'h0000, "turnaround");
    chk(d, exp, what);
  endtask : rd

  task automatic wr(input logic [4:0] ra, input logic [15:0] v);
    logic [15:0] d;
    logic t;
    pesb_smi_master_inst.frame(`PESB_OP_WR, PHY, ra, v, d, t);
  endtask : wr

  // Bypass bits 15, 8..3, 1, 0 in the order of the control struct
  function automatic logic [15:0] cmap(input logic [15:0] v);
    return {7'h00, v[15], v[8:3], v[1:0]};
  endfunction : cmap

  task automatic chk_ctrl(input logic [15:0] v);
    chk({7'h00, ctrl}, cmap(v), "ctrl");
  endtask : chk_ctrl

  task automatic pulse(input pesb_fast_evt_t f, input pesb_giga_evt_t g);
    @(negedge clk);
    fevt = f;
    gevt = g;
    @(negedge clk);
    fevt = '0;
    gevt = '0;
  endtask : pulse

  task automatic test_done();
    if (n_fail == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : test_done

  // About 65 frames of about 715 clk each are expected
  initial begin
    repeat (80000) @(posedge clk);
    n_fail++;
    $display("BAD %0t watchdog expired", $time);
    test_done();
  end

  initial begin
    logic [15:0] d;
    logic t;
    repeat (16) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    chk_ctrl(16'h0049);
    rd(`PESB_ADDR_BYP, 16'h0049, "bypass reset");
    wr(`PESB_ADDR_GCAP, 16'hffff);
    rd(`PESB_ADDR_GCAP, 16'h3000, "capability");
    for (int a = 11; a <= 14; a++) begin
      wr(5'(a), 16'hffff);
      rd(5'(a), 16'h0000, "reserved");
    end
    wr(`PESB_ADDR_FAST, 16'hffff);
    wr(`PESB_ADDR_GIGA, 16'hffff);
    rd(`PESB_ADDR_FAST, 16'h0000, "fast idle");
    rd(`PESB_ADDR_GIGA, 16'h0000, "giga idle");
    for (int i = 0; i < 10; i++) begin
      wr(`PESB_ADDR_BYP, BYP_VALS[i]);
      chk_ctrl(BYP_VALS[i]);
      rd(`PESB_ADDR_BYP, BYP_VALS[i] & 16'h81fb, "bypass");
    end
    // Legacy partner detection: enabled, disabled, then forced over the disable
    raw = 1'b1;
    wr(`PESB_ADDR_BYP, 16'h0000);
    chk(16'(leg_flag), 16'h0001, "legacy on");
    rd(`PESB_ADDR_GIGA, 16'h0040, "legacy read");
    wr(`PESB_ADDR_BYP, 16'h0040);
    chk(16'(leg_flag), 16'h0000, "legacy off");
    raw = 1'b0;
    wr(`PESB_ADDR_BYP, 16'h00c0);
    chk(16'(leg_flag), 16'h0001, "legacy forced");
    wr(`PESB_ADDR_BYP, 16'h0048);
    xover = 1'b1;
    rd(`PESB_ADDR_GIGA, 16'h0020, "crossover");
    xover = 1'b0;
    // Each error flag alone, so a swapped bit shows up
    flive = 2'b11;
    glive = 2'b11;
    for (int i = 0; i < 6; i++) begin
      pulse(6'h20 >> i, '0);
      rd(`PESB_ADDR_FAST, 16'h9000 | FAST_BITS[i], "fast latch");
    end
    rd(`PESB_ADDR_FAST, 16'h9000, "fast cleared");
    for (int i = 0; i < 7; i++) begin
      pulse('0, 7'h40 >> i);
      rd(`PESB_ADDR_GIGA, 16'h9000 | GIGA_BITS[i], "giga latch");
    end
    rd(`PESB_ADDR_GIGA, 16'h9000, "giga cleared");
    flive = 2'b00;
    glive = 2'b00;
    rd(`PESB_ADDR_FAST, 16'h0000, "fast live low");
    // Soft reset keeps sticky bits and drops latched flags
    wr(`PESB_ADDR_BYP, 16'hffff);
    pulse(6'h3f, 7'h7f);
    @(negedge clk);
    soft_reset = 1'b1;
    @(negedge clk);
    soft_reset = 1'b0;
    @(negedge clk);
    chk_ctrl(16'h00fb);
    rd(`PESB_ADDR_BYP, 16'h00fb, "soft reset");
    rd(`PESB_ADDR_FAST, 16'h0000, "fast soft");
    rd(`PESB_ADDR_GIGA, 16'h0040, "giga soft");
    // Another station address is never answered and never written
    pesb_smi_master_inst.frame(`PESB_OP_WR, PHY ^ 5'h01, `PESB_ADDR_BYP, 16'h0000, d, t);
    pesb_smi_master_inst.frame(`PESB_OP_RD, PHY ^ 5'h01, `PESB_ADDR_BYP, 16'h0000, d, t);
    chk(d, 16'hffff, "foreign read");
    rd(`PESB_ADDR_BYP, 16'h00fb, "foreign write");
    // Hardware reset restores every default, bit 0 from the strap
    strap = 1'b0;
    rst = 1'b1;
    repeat (16) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    rd(`PESB_ADDR_BYP, 16'h0048, "hard reset");
    test_done();
  end
endmodule : pesb_regs_tb_top
